// File: verilog/uocr_pkg.sv
`default_nettype none
package uocr_pkg;
    // Register byte offsets on APB
    localparam logic [11:0] OFS_CFG1   = 12'h000;
    localparam logic [11:0] OFS_CFG2   = 12'h004;
    localparam logic [11:0] OFS_STATUS = 12'h008;
    localparam logic [11:0] OFS_ENABLE = 12'h00c;
    localparam logic [11:0] OFS_LIVE   = 12'h010;
    // Writable masks (unimplemented bits read zero)
    localparam logic [15:0] CFG1_MASK  = 16'h00d3;
    localparam logic [15:0] CFG2_MASK  = 16'h001f;
    localparam logic [15:0] EVT_MASK   = 16'h00fd;
    localparam logic [15:0] RST_VAL    = 16'h0000;
    // Configuration one fields
    localparam int B_EYE    = 7;
    localparam int B_OEMON  = 6;
    localparam int B_SIDL   = 4;
    localparam int B_PP     = 0;
    // Configuration two fields
    localparam int B_PUVB   = 4;
    localparam int B_EXTSER = 3;
    localparam int B_BOOST  = 2;
    localparam int B_VCMP   = 1;
    localparam int B_XCVR   = 0;
    // Event flag positions
    localparam int F_ID     = 7;
    localparam int F_MS     = 6;
    localparam int F_LS     = 5;
    localparam int F_ACT    = 4;
    localparam int F_SESV   = 3;
    localparam int F_BSE    = 2;
    localparam int F_AVV    = 0;
    // Ping-pong modes
    localparam logic [1:0] PP_OFF  = 2'h0;
    localparam logic [1:0] PP_EP0O = 2'h1;
    localparam logic [1:0] PP_ALL  = 2'h2;
    localparam logic [1:0] PP_EP1  = 2'h3;
    // Timing
    localparam int CLK_HZ     = 50000000;
    localparam int MS_TIME_US = 1000;
    localparam int MS_CYCLES  = (CLK_HZ / 1000000) * MS_TIME_US;
    // Live bus inputs
    typedef struct packed {
        logic dp;
        logic dm;
        logic id;
        logic a_sess_end;
        logic b_sess_end;
        logic a_vbus_vld;
    } uocr_bus_s;
endpackage
`default_nettype wire

// File: verilog/uocr_regs.sv
// Design decisions made here: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module uocr_regs #(
    parameter int MS_COUNT = uocr_pkg::MS_CYCLES  // Cycles per millisecond
) (
    // Clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    // APB slave
    input  wire logic             i_psel,
    input  wire logic             i_penable,
    input  wire logic             i_pwrite,
    input  wire logic [11:0]      i_paddr,
    input  wire logic [31:0]      i_pwdata,
    output logic      [31:0]      o_prdata,
    output logic                  o_pready,
    output logic                  o_pslverr,
    // Bus side inputs
    input  wire uocr_pkg::uocr_bus_s i_bus,
    input  wire logic             i_line_drive,
    input  wire logic             i_cpu_idle,
    // Configuration outputs
    output logic                  o_eye_test_en,
    output logic                  o_drive_oe_n,
    output logic                  o_module_halt,
    output logic      [1:0]       o_pingpong_cfg,
    output logic                  o_vbus_pullup_en,
    output logic                  o_ext_ctrl_serial_sel,
    output logic                  o_ext_ctrl_pins_en,
    output logic                  o_boost_onchip_en,
    output logic                  o_boost_digital_en,
    output logic                  o_vbus_cmp_onchip_en,
    output logic                  o_vbus_digital_en,
    output logic                  o_xcvr_onchip_en,
    output logic                  o_xcvr_digital_en,
    // Interrupt request
    output logic                  o_otg_irq
);
    // Registers
    logic [15:0] cfg1_q;             // Configuration one
    logic [15:0] cfg2_q;             // Configuration two
    logic [15:0] stat_q;             // Sticky event flags
    logic [15:0] ien_q;              // Event enables
    logic [15:0] stat_d;             // Next flags
    logic [15:0] set_w;              // Hardware set pulses
    logic [5:0]  bus_prev_q;         // Previous bus sample
    logic [31:0] ms_cnt_q;           // Millisecond divider
    logic        ms_tick;            // One-cycle millisecond pulse
    logic [1:0]  ls_cur;             // Present line state
    logic [1:0]  ls_cand_q;          // Candidate line state
    logic [1:0]  ls_stable_q;        // Last stable line state
    logic [31:0] ls_cnt_q;           // Steady time counter
    logic        ls_hit;             // Steady for 1 ms and new
    logic        run;                // Module running
    // APB decode
    wire         acc    = i_psel & i_penable;
    wire         wr     = acc & i_pwrite;
    wire         hit_c1 = (i_paddr == uocr_pkg::OFS_CFG1);
    wire         hit_c2 = (i_paddr == uocr_pkg::OFS_CFG2);
    wire         hit_st = (i_paddr == uocr_pkg::OFS_STATUS);
    wire         hit_ie = (i_paddr == uocr_pkg::OFS_ENABLE);
    wire         hit_lv = (i_paddr == uocr_pkg::OFS_LIVE);
    wire         mapped = hit_c1 | hit_c2 | hit_st | hit_ie | hit_lv;
    wire  [15:0] wdat   = i_pwdata[15:0];

    // Zero-wait slave; unmapped addresses answer with an error
    assign o_pready  = 1'b1;
    assign o_pslverr = acc & ~mapped;

    // Module halted in idle when stop-in-idle is set
    assign run = ~(cfg1_q[uocr_pkg::B_SIDL] & i_cpu_idle);
    assign o_module_halt = ~run;

    // Configuration outputs from register bits; on-chip enables and ext pins are the inverted bits
    assign o_eye_test_en         = cfg1_q[uocr_pkg::B_EYE];
    assign o_pingpong_cfg        = cfg1_q[uocr_pkg::B_PP +: 2];
    assign o_vbus_pullup_en      = cfg2_q[uocr_pkg::B_PUVB];
    assign o_ext_ctrl_serial_sel = cfg2_q[uocr_pkg::B_EXTSER];
    assign o_ext_ctrl_pins_en    = ~cfg2_q[uocr_pkg::B_EXTSER];
    assign o_boost_onchip_en     = ~cfg2_q[uocr_pkg::B_BOOST];
    assign o_boost_digital_en    = cfg2_q[uocr_pkg::B_BOOST];
    assign o_vbus_cmp_onchip_en  = ~cfg2_q[uocr_pkg::B_VCMP];
    assign o_vbus_digital_en     = cfg2_q[uocr_pkg::B_VCMP];
    assign o_xcvr_onchip_en      = ~cfg2_q[uocr_pkg::B_XCVR];
    assign o_xcvr_digital_en     = cfg2_q[uocr_pkg::B_XCVR];

    // Drive indicator: low while lines driven, only with monitor and digital path
    assign o_drive_oe_n = ~(cfg1_q[uocr_pkg::B_OEMON] & cfg2_q[uocr_pkg::B_XCVR]
                            & i_line_drive);

    // Line state: both lines low gives SE0, else J is D+ high (full speed)
    assign ls_cur = {~i_bus.dp & ~i_bus.dm, i_bus.dp & ~i_bus.dm};
    assign ls_hit = run & (ls_cnt_q == MS_COUNT - 1) & (ls_cand_q != ls_stable_q);
    assign ms_tick = run & (ms_cnt_q == MS_COUNT - 1);

    // Event pulses; bus inputs are sampled so every edge while running counts once, edges while halted are dropped
    always_comb begin
        set_w = 16'h0000;
        set_w[uocr_pkg::F_ID]   = i_bus.id != bus_prev_q[3];
        set_w[uocr_pkg::F_MS]   = ms_tick;
        set_w[uocr_pkg::F_LS]   = ls_hit;
        set_w[uocr_pkg::F_ACT]  = (i_bus.dp != bus_prev_q[5])
                                | (i_bus.dm != bus_prev_q[4])
                                | (i_bus.a_vbus_vld != bus_prev_q[0]);
        set_w[uocr_pkg::F_SESV] = i_bus.a_sess_end != bus_prev_q[2];
        set_w[uocr_pkg::F_BSE]  = i_bus.b_sess_end != bus_prev_q[1];
        set_w[uocr_pkg::F_AVV]  = i_bus.a_vbus_vld != bus_prev_q[0];
        if (!run) begin
            set_w = 16'h0000;
        end
    end

    // Write-one-to-clear, set wins over clear, flags sticky
    always_comb begin
        stat_d = stat_q;
        if (wr && hit_st) begin
            stat_d = stat_q & ~wdat;
        end
        stat_d = (stat_d | set_w) & uocr_pkg::EVT_MASK;
    end

    // Interrupt request from any enabled flag
    assign o_otg_irq = |(stat_q & ien_q);

    // Register writes
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cfg1_q <= uocr_pkg::RST_VAL;
            cfg2_q <= uocr_pkg::RST_VAL;
            ien_q  <= uocr_pkg::RST_VAL;
            stat_q <= uocr_pkg::RST_VAL;
        end else begin
            stat_q <= stat_d;
            if (wr && hit_c1) begin
                cfg1_q <= wdat & uocr_pkg::CFG1_MASK;
            end
            // Disable bits stay put only if software honours the power rule
            if (wr && hit_c2) begin
                cfg2_q <= wdat & uocr_pkg::CFG2_MASK;
            end
            if (wr && hit_ie) begin
                ien_q <= wdat & uocr_pkg::EVT_MASK;
            end
        end
    end

    // Previous bus sample; reset to zero, so any bus input high after reset raises an event
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            bus_prev_q <= 6'h00;
        end else begin
            bus_prev_q <= {i_bus.dp, i_bus.dm, i_bus.id,
                           i_bus.a_sess_end, i_bus.b_sess_end, i_bus.a_vbus_vld};
        end
    end

    // Free-running millisecond divider, paused when halted
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ms_cnt_q <= 32'h0;
        end else if (ms_tick) begin
            ms_cnt_q <= 32'h0;
        end else if (run) begin
            ms_cnt_q <= ms_cnt_q + 32'h1;
        end
    end

    // Line state steady timer; restarts whenever the state moves
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ls_cand_q   <= 2'h0;
            ls_stable_q <= 2'h0;
            ls_cnt_q    <= 32'h0;
        end else if (run) begin
            if (ls_cur != ls_cand_q) begin
                ls_cand_q <= ls_cur;
                ls_cnt_q  <= 32'h0;
            end else if (ls_cnt_q != MS_COUNT - 1) begin
                ls_cnt_q <= ls_cnt_q + 32'h1;
            end else begin
                ls_stable_q <= ls_cand_q;
            end
        end
    end

    // Read mux, registered data output
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_prdata <= 32'h0;
        end else if (i_psel && !i_penable && !i_pwrite) begin
            o_prdata <= 32'h0;
            if (hit_c1) o_prdata <= {16'h0000, cfg1_q};
            if (hit_c2) o_prdata <= {16'h0000, cfg2_q};
            if (hit_st) o_prdata <= {16'h0000, stat_q};
            if (hit_ie) o_prdata <= {16'h0000, ien_q};
            if (hit_lv) o_prdata <= {26'h0, ls_stable_q, ls_cur, 1'b0, run};
        end
    end
endmodule
`default_nettype wire

// File: tb/uocr_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// Pin-level checks on the register block
module uocr_monitor (
    // Clock, reset and APB
    input wire logic        i_clk,
    input wire logic        i_rst,
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic        o_pslverr,
    // Side inputs and decoded outputs
    input wire logic        i_line_drive,
    input wire logic        i_cpu_idle,
    input wire logic        o_eye_test_en,
    input wire logic        o_drive_oe_n,
    input wire logic        o_module_halt,
    input wire logic        o_vbus_pullup_en,
    input wire logic        o_xcvr_onchip_en,
    input wire logic        o_xcvr_digital_en,
    input wire logic        o_otg_irq
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // Write access phases per register
    wire wr    = i_psel && i_penable && i_pwrite;
    wire c1_wr = wr && i_paddr == 12'h000;
    wire c2_wr = wr && i_paddr == 12'h004;
    wire ie_wr = wr && i_paddr == 12'h00c;
    eye_follows_a: assert property (c1_wr |=> o_eye_test_en == $past(i_pwdata[7]))
        else $error("eye test enable wrong");
    pullup_follows_a: assert property (
        c2_wr |=> o_vbus_pullup_en == $past(i_pwdata[4]))
        else $error("vbus pullup wrong");
    oe_needs_drive_a: assert property (!o_drive_oe_n |-> i_line_drive)
        else $error("drive indicator without drive");
    oe_needs_xdis_a: assert property (!o_drive_oe_n |-> o_xcvr_digital_en)
        else $error("drive indicator with on-chip transceiver");
    halt_needs_idle_a: assert property (o_module_halt |-> i_cpu_idle)
        else $error("halt outside idle");
    xcvr_path_excl_a: assert property (o_xcvr_onchip_en ^ o_xcvr_digital_en)
        else $error("transceiver paths not exclusive");
    irq_masked_a: assert property (
        ie_wr && i_pwdata[7:0] == 8'h00 |-> ##[1:2] !o_otg_irq)
        else $error("irq with all enables off");
    bad_addr_err_a: assert property (
        i_psel && i_penable && i_paddr > 12'h010 |-> o_pslverr)
        else $error("no error on unmapped access");
    cover property (wr && i_paddr == 12'h008);
    cover property (!o_drive_oe_n);
    cover property (o_otg_irq ##1 !o_otg_irq);
    cover property (o_module_halt);
endmodule
`default_nettype wire

// File: tb/uocr_xcvr_model.sv
`timescale 1ns/1ps
`default_nettype none
// Far-side levels: applies requested levels after a lag, so slow parts are covered
module uocr_xcvr_model (
    input  wire logic                i_clk,
    input  wire logic                i_rst,
    input  wire uocr_pkg::uocr_bus_s i_want,
    input  wire logic [3:0]          i_lag,
    output var  uocr_pkg::uocr_bus_s o_bus
);
    logic [3:0] wait_q;  // Cycles a new level has waited
    // Lines read all low in reset, like an unpowered transceiver
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_bus  <= '0;
            wait_q <= 4'h0;
        end else if (i_want == o_bus || wait_q >= i_lag) begin
            o_bus  <= i_want;
            wait_q <= 4'h0;
        end else begin
            wait_q <= wait_q + 4'h1;
        end
    end
endmodule
`default_nettype wire

// File: tb/uocr_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
module uocr_regs_test;
    // APB master, reset and side inputs
    logic i_clk = 1'b0, i_rst = 1'b1, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
    logic i_line_drive = 1'b0, i_cpu_idle = 1'b0, err;
    logic [11:0] i_paddr = 12'h000;
    logic [31:0] i_pwdata = 32'h0, rd, o_prdata;
    logic [3:0] lag = 4'h0;
    uocr_pkg::uocr_bus_s i_bus, want = 6'h20;  // Idle J state, D+ high
    // Design outputs
    logic o_pready, o_pslverr, o_otg_irq, o_module_halt, o_drive_oe_n, o_eye_test_en;
    logic o_vbus_pullup_en, o_ext_ctrl_serial_sel, o_ext_ctrl_pins_en, o_boost_onchip_en;
    logic o_boost_digital_en, o_vbus_cmp_onchip_en, o_vbus_digital_en, o_xcvr_onchip_en;
    logic o_xcvr_digital_en;
    logic [1:0] o_pingpong_cfg;
    int n_mismatch = 0, samples_checked = 0;
    // Decoded fields and their on-chip complements
    wire [7:0] outs = {o_eye_test_en, o_pingpong_cfg, o_vbus_pullup_en, o_ext_ctrl_serial_sel,
                       o_boost_digital_en, o_vbus_digital_en, o_xcvr_digital_en};
    wire [3:0] onch = {o_ext_ctrl_pins_en, o_boost_onchip_en,
                       o_vbus_cmp_onchip_en, o_xcvr_onchip_en};
    // Rows: address, write data, read-back, decoded outputs
    typedef struct packed {
        logic [11:0] a;
        logic [15:0] wd;
        logic [15:0] rb;
        logic [7:0]  o;
    } uocr_row_s;
    uocr_row_s rows [10] = '{'{12'h000, 16'hffff, 16'h00d3, 8'he0},
        '{12'h000, 16'h0081, 16'h0081, 8'ha0}, '{12'h000, 16'h0002, 16'h0002, 8'h40},
        '{12'h000, 16'h0000, 16'h0000, 8'h00}, '{12'h004, 16'hffff, 16'h001f, 8'h1f},
        '{12'h004, 16'h0014, 16'h0014, 8'h14}, '{12'h004, 16'h000a, 16'h000a, 8'h0a},
        '{12'h00c, 16'hffff, 16'h00fd, 8'h0a}, '{12'h00c, 16'h0000, 16'h0000, 8'h0a},
        '{12'h004, 16'h0000, 16'h0000, 8'h00}};
    logic [7:0] vexp [3] = '{8'h11, 8'h04, 8'h08};  // Flags per threshold line
    uocr_regs #(.MS_COUNT(20)) dut_u (.*);
    uocr_xcvr_model far_u (.i_clk(i_clk), .i_rst(i_rst), .i_want(want), .i_lag(lag),
                           .o_bus(i_bus));
    always #10 i_clk = ~i_clk;
    task automatic test_done;
        if (n_mismatch == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    // One APB transfer, then an idle cycle so no signal is driven twice per step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1'b1;
        for (n = 0; n < 8; n++) begin
            @(posedge i_clk);
            if (o_pready === 1'b1) break;
        end
        if (n == 8) chk(0, 1, "pready timeout");
        if (n == 8) test_done();
        rd = o_prdata;
        err = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        @(posedge i_clk);
    endtask
    task automatic stat(input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, 12'h008, 32'h0);
        chk(rd & m, e, "status");
    endtask
    initial begin
        tick(8);
        i_rst <= 1'b0;
        foreach (vexp[k]) begin
            apb(1'b0, 12'h000 + 12'(4 * k + (k / 2) * 4), 32'h0);
            chk(rd, 0, "reset value");
        end
        // Module power is off here, so disable bits may change
        foreach (rows[k]) begin
            apb(1'b1, rows[k].a, {16'h0000, rows[k].wd});
            chk(outs, rows[k].o, "outputs");
            chk(onch ^ outs[3:0], 4'hf, "on-chip paths");
            apb(1'b0, rows[k].a, 32'h0);
            chk(rd, {16'h0000, rows[k].rb}, "read back");
        end
        tick(30);
        apb(1'b1, 12'h008, 32'hffff);
        stat(32'hffbf, 32'h0);
        apb(1'b1, 12'h00c, 32'h80);
        want.id <= 1'b1;
        tick(4);
        stat(32'hffbf, 32'h80);
        chk(o_otg_irq, 1, "irq on");
        apb(1'b1, 12'h00c, 32'h0);
        tick(2);
        chk(o_otg_irq, 0, "irq masked");
        apb(1'b1, 12'h008, 32'h0);
        stat(32'h80, 32'h80);
        apb(1'b1, 12'h008, 32'h80);
        stat(32'h80, 32'h0);
        want.id <= 1'b0;
        lag <= 4'h9;
        // The lagged ID return must land before the loop clears the flags
        tick(14);
        for (int k = 0; k < 6; k++) begin
            apb(1'b1, 12'h008, 32'hffff);
            want[k % 3] <= ~want[k % 3];
            tick(14);
            stat(32'hbf, {24'h0, vexp[k % 3]});
        end
        lag <= 4'h0;
        want.dp <= 1'b0;
        tick(3);
        stat(32'h30, 32'h10);
        tick(25);
        stat(32'h20, 32'h20);
        apb(1'b1, 12'h008, 32'hffff);
        tick(25);
        stat(32'h20, 32'h0);
        apb(1'b1, 12'h008, 32'hffff);
        tick(21);
        stat(32'h40, 32'h40);
        i_cpu_idle <= 1'b1;
        apb(1'b1, 12'h000, 32'h10);
        chk(o_module_halt, 1, "halt in idle");
        apb(1'b1, 12'h008, 32'hffff);
        tick(25);
        stat(32'h40, 32'h0);
        apb(1'b1, 12'h000, 32'h40);
        chk(o_module_halt, 0, "run in idle");
        i_line_drive <= 1'b1;
        tick(1);
        chk(o_drive_oe_n, 1, "monitor ignored");
        apb(1'b1, 12'h004, 32'h1);
        chk(o_drive_oe_n, 0, "drive shown");
        i_line_drive <= 1'b0;
        tick(1);
        chk(o_drive_oe_n, 1, "no drive");
        apb(1'b1, 12'h020, 32'hffff);
        chk(err, 1, "unmapped error");
        apb(1'b0, 12'h020, 32'h0);
        chk(rd, 0, "unmapped read");
        // Mid-run reset clears every register
        i_rst <= 1'b1;
        tick(2);
        i_rst <= 1'b0;
        chk({o_eye_test_en, o_drive_oe_n, o_xcvr_digital_en}, 3'h2, "reset outputs");
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 0, "cfg2 after reset");
        stat(32'h9f, 32'h0);
        test_done();
    end
endmodule
bind uocr_regs uocr_monitor mon_u (.*);
`default_nettype wire
